// file: usb_interrupt_autovector.sv
// Second-level interrupt vectoring for the USB event and FIFO/interface lines
module usb_interrupt_autovector
	import autovector_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic usb_autovector_enable,
	input wire logic fifo_autovector_enable,
	input wire logic [USB_SLOTS-1:0] usb_pending,
	input wire logic [FIFO_SLOTS-1:0] fifo_pending,
	input wire logic [15:0] code_addr,
	input wire logic [7:0] code_rdata,
	output logic [7:0] code_fetch_data,
	output logic usb_event_irq,
	output logic fifo_iface_irq,
	output logic [7:0] usb_vector_byte,
	output logic [7:0] fifo_vector_byte
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0] usb_vec;
		logic [7:0] fifo_vec;
		logic usb_irq;
		logic fifo_irq;
	} state_t;

	state_t state;
	state_t next_state;
	logic [USB_SLOTS-1:0] usb_live;
	logic [7:0] usb_pick;
	logic [7:0] fifo_pick;
	logic usb_any;
	logic fifo_any;

	// Reserved slots never raise the line
	assign usb_live = usb_pending & ~USB_RESERVED_MASK; // R5 R8 R10

	// Priority encoders, lowest slot number wins
	always_comb begin
		usb_pick = USB_VEC_BASE;
		usb_any = 1'b0;
		for (int i = USB_SLOTS - 1; i >= 0; i--) begin // R12
			if (usb_live[i]) begin
				usb_pick = USB_VEC_BASE + 8'(i * SLOT_STEP); // R5 R6 R7 R8 R9 R10 R11
				usb_any = 1'b1;
			end
		end
		fifo_pick = FIFO_VEC_BASE;
		fifo_any = 1'b0;
		for (int j = FIFO_SLOTS - 1; j >= 0; j--) begin
			if (fifo_pending[j]) begin
				fifo_pick = FIFO_VEC_BASE + 8'(j * SLOT_STEP); // R14
				fifo_any = 1'b1;
			end
		end
	end

	// Next state: vector bytes track the winning pending source
	always_comb begin
		next_state = state;
		next_state.usb_irq = usb_any; // R1
		next_state.fifo_irq = fifo_any; // R1
		if (usb_any) begin
			next_state.usb_vec = usb_pick; // R12
		end
		if (fifo_any) begin
			next_state.fifo_vec = fifo_pick;
		end
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '{usb_vec: USB_VEC_BASE, fifo_vec: FIFO_VEC_BASE, usb_irq: 1'b0, fifo_irq: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	// Outputs come straight from the state register
	assign usb_event_irq = state.usb_irq; // R2
	assign fifo_iface_irq = state.fifo_irq; // R13
	assign usb_vector_byte = state.usb_vec;
	assign fifo_vector_byte = state.fifo_vec;

	// Code fetch path: vector byte replaces the stored low address byte
	always_comb begin
		code_fetch_data = code_rdata; // R4
		if (code_addr == USB_VEC_ADDR && usb_autovector_enable) begin
			code_fetch_data = state.usb_vec; // R3 R4
		end else if (code_addr == FIFO_VEC_ADDR && fifo_autovector_enable) begin
			code_fetch_data = state.fifo_vec; // R13
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_usb_subst;
		@(posedge clk) disable iff (!arst_n)
		(code_addr == USB_VEC_ADDR && usb_autovector_enable) |-> code_fetch_data == usb_vector_byte;
	endproperty
	a_usb_subst: assert property (p_usb_subst) else $error("usb vector not substituted"); // R3

	property p_usb_pass;
		@(posedge clk) disable iff (!arst_n)
		(code_addr == USB_VEC_ADDR && !usb_autovector_enable) |-> code_fetch_data == code_rdata;
	endproperty
	a_usb_pass: assert property (p_usb_pass) else $error("stored byte altered"); // R3

	property p_page_pass;
		@(posedge clk) disable iff (!arst_n)
		(code_addr == USB_PAGE_ADDR || code_addr == USB_JUMP_ADDR) |-> code_fetch_data == code_rdata;
	endproperty
	a_page_pass: assert property (p_page_pass) else $error("page byte altered"); // R4

	property p_fifo_subst;
		@(posedge clk) disable iff (!arst_n)
		(code_addr == FIFO_VEC_ADDR && fifo_autovector_enable) |-> code_fetch_data == fifo_vector_byte;
	endproperty
	a_fifo_subst: assert property (p_fifo_subst) else $error("fifo vector not substituted"); // R13

	property p_fifo_page;
		@(posedge clk) disable iff (!arst_n)
		(code_addr == FIFO_PAGE_ADDR || code_addr == FIFO_JUMP_ADDR) |-> code_fetch_data == code_rdata;
	endproperty
	a_fifo_page: assert property (p_fifo_page) else $error("fifo page byte altered"); // R13

	property p_top_prio;
		@(posedge clk) disable iff (!arst_n)
		usb_pending[0] |=> usb_vector_byte == 8'h00;
	endproperty
	a_top_prio: assert property (p_top_prio) else $error("setup data not highest"); // R12

	property p_sof_vec;
		@(posedge clk) disable iff (!arst_n)
		(usb_pending[1:0] == 2'b10) |=> usb_vector_byte == 8'h04;
	endproperty
	a_sof_vec: assert property (p_sof_vec) else $error("frame vector wrong"); // R5

	property p_reserved;
		@(posedge clk) disable iff (!arst_n)
		((usb_pending & 32'hf1fd_ff7f) == 32'h0) |=> !usb_event_irq;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved slot raised line"); // R5

	property p_iso_vec;
		@(posedge clk) disable iff (!arst_n)
		(usb_pending == 32'h8000_0000) |=> usb_event_irq && usb_vector_byte == 8'h7c;
	endproperty
	a_iso_vec: assert property (p_iso_vec) else $error("iso error vector wrong"); // R11

	property p_fifo_last;
		@(posedge clk) disable iff (!arst_n)
		(fifo_pending == 14'h2000) |=> fifo_iface_irq && fifo_vector_byte == 8'hb4;
	endproperty
	a_fifo_last: assert property (p_fifo_last) else $error("waveform vector wrong"); // R14

	// Control IN slot wins when nothing above it is pending
	property p_ctrl_in_vec;
		@(posedge clk) disable iff (!arst_n)
		(usb_pending[8:0] == 9'h100) |=> usb_vector_byte == 8'h20;
	endproperty
	a_ctrl_in_vec: assert property (p_ctrl_in_vec) else $error("ctrl in vector wrong"); // R6

	// First buffered endpoint slot
	property p_ep2_vec;
		@(posedge clk) disable iff (!arst_n)
		(usb_pending[12:0] == 13'h1000) |=> usb_vector_byte == 8'h30;
	endproperty
	a_ep2_vec: assert property (p_ep2_vec) else $error("ep2 vector wrong"); // R7

	// Bulk IN NAK slot
	property p_bulk_nak_vec;
		@(posedge clk) disable iff (!arst_n)
		(usb_pending[16:0] == 17'h1_0000) |=> usb_vector_byte == 8'h40;
	endproperty
	a_bulk_nak_vec: assert property (p_bulk_nak_vec) else $error("bulk nak vector wrong"); // R8

	// Control OUT ping NAK slot
	property p_ping_vec;
		@(posedge clk) disable iff (!arst_n)
		(usb_pending[18:0] == 19'h4_0000) |=> usb_vector_byte == 8'h48;
	endproperty
	a_ping_vec: assert property (p_ping_vec) else $error("ping vector wrong"); // R9

	// Bus error limit slot
	property p_err_vec;
		@(posedge clk) disable iff (!arst_n)
		(usb_pending[24:0] == 25'h100_0000) |=> usb_vector_byte == 8'h60;
	endproperty
	a_err_vec: assert property (p_err_vec) else $error("error limit vector wrong"); // R10

	// Any live USB source raises the line one cycle later
	property p_usb_irq;
		@(posedge clk) disable iff (!arst_n)
		(|(usb_pending & 32'hf1fd_ff7f)) |=> usb_event_irq;
	endproperty
	a_usb_irq: assert property (p_usb_irq) else $error("usb line not raised"); // R1

	// With no live source the last winner is kept
	property p_usb_hold;
		@(posedge clk) disable iff (!arst_n)
		((usb_pending & 32'hf1fd_ff7f) == 32'h0) |=> $stable(usb_vector_byte);
	endproperty
	a_usb_hold: assert property (p_usb_hold) else $error("usb vector moved while idle"); // R12

	// FIFO line drops when nothing is pending
	property p_fifo_quiet;
		@(posedge clk) disable iff (!arst_n)
		(fifo_pending == 14'h0000) |=> !fifo_iface_irq;
	endproperty
	a_fifo_quiet: assert property (p_fifo_quiet) else $error("fifo line raised idle"); // R1

	// First FIFO slot always wins
	property p_fifo_first;
		@(posedge clk) disable iff (!arst_n)
		fifo_pending[0] |=> fifo_iface_irq && fifo_vector_byte == 8'h80;
	endproperty
	a_fifo_first: assert property (p_fifo_first) else $error("fifo first vector wrong"); // R14

	// Second FIFO slot wins over all below it
	property p_fifo_prio;
		@(posedge clk) disable iff (!arst_n)
		(fifo_pending[1:0] == 2'b10) |=> fifo_vector_byte == 8'h84;
	endproperty
	a_fifo_prio: assert property (p_fifo_prio) else $error("fifo priority wrong"); // R12
endmodule : usb_interrupt_autovector

// file: autovector_pkg.sv
// Constants for the interrupt autovector block
// Summary of operation
// (R1) Autovector two shared lines: USB events 27 slots, FIFO/interface 14 slots.
// (R2) USB event interrupt fetches its jump instruction from code address 0x0043.
// (R3) Substitute the USB vector byte only while the USB autovector enable is 1.
// (R4) Firmware preloads handler page at 0x0044; block supplies vector byte at 0x0045.
// (R5) Vectors 00..18 for setup, frame, token, suspend, reset, high speed, handshake; 1C reserved.
// (R6) Vectors 20..2C for control IN/OUT and endpoint 1 IN/OUT events.
// (R7) Vectors 30..3C for endpoints 2, 4, 6, 8 buffer events.
// (R8) Vector 40 when any IN endpoint NAKs a bulk IN; 44 reserved.
// (R9) Vectors 48..5C for ping NAK on OUT endpoints 0, 1, 2, 4, 6, 8.
// (R10) Vector 60 when bus errors exceed limit; 64..6C have no source.
// (R11) Vectors 70..7C for isochronous PID sequence errors on endpoints 2..8.
// (R12) Smallest priority pending source wins; others wait until it clears.
// (R13) FIFO line fetches at 0x0053; vector byte at 0x0055, page at 0x0054.
// (R14) FIFO vectors: flags 80..8C, empty 90..9C, full A0..AC, done B0, waveform B4.
package autovector_pkg;
	// ****************************************************************
	// Widths and slot counts
	// ****************************************************************
	localparam int unsigned USB_SLOTS = 32;
	localparam int unsigned FIFO_SLOTS = 14;
	localparam int unsigned SLOT_STEP = 4;
	localparam logic [7:0] USB_VEC_BASE = 8'h00;
	localparam logic [7:0] FIFO_VEC_BASE = 8'h80;
	// ****************************************************************
	// Code addresses of the jump table entries
	// ****************************************************************
	localparam logic [15:0] USB_JUMP_ADDR = 16'h0043;
	localparam logic [15:0] USB_PAGE_ADDR = 16'h0044;
	localparam logic [15:0] USB_VEC_ADDR = 16'h0045;
	localparam logic [15:0] FIFO_JUMP_ADDR = 16'h0053;
	localparam logic [15:0] FIFO_PAGE_ADDR = 16'h0054;
	localparam logic [15:0] FIFO_VEC_ADDR = 16'h0055;
	// Slots of the USB table that have no source
	localparam logic [31:0] USB_RESERVED_MASK = 32'h0e02_0080;
endpackage : autovector_pkg

// file: code_memory.sv
// Code memory model answering the core's jump table fetches
module code_memory (
	input wire logic [15:0] code_addr,
	output logic [7:0] code_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Jump opcode and preloaded pages; other places give an address-dependent pattern
	always_comb begin
		case (code_addr)
			16'h0043, 16'h0053: code_rdata = 8'h02;
			16'h0044: code_rdata = 8'h12;
			16'h0054: code_rdata = 8'h34;
			default: code_rdata = ~code_addr[7:0];
		endcase
	end
endmodule : code_memory

// file: testbench.sv
// Self-checking bench for the interrupt autovector block
module testbench import autovector_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] USB_RSV = 32'h0e02_0080; // Slots 1C, 44, 64..6C
	logic clk, arst_n, ue, fe, ui, fi;
	logic [31:0] up;
	logic [13:0] fp;
	logic [15:0] ca;
	logic [7:0] cr, cf, uvb, fvb, euv, efv;
	int n_fail, compares;
	usb_interrupt_autovector uut (.clk(clk), .arst_n(arst_n), .usb_autovector_enable(ue),
		.fifo_autovector_enable(fe), .usb_pending(up), .fifo_pending(fp), .code_addr(ca),
		.code_rdata(cr), .code_fetch_data(cf), .usb_event_irq(ui), .fifo_iface_irq(fi),
		.usb_vector_byte(uvb), .fifo_vector_byte(fvb));
	code_memory mem (.code_addr(ca), .code_rdata(cr));
	// Clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Lowest pending slot wins, reported as found flag and vector
	function automatic logic [8:0] pick(input logic [31:0] p, input int n, input logic [7:0] base);
		pick = 9'h000;
		for (int i = n - 1; i >= 0; i--) if (p[i]) pick = {1'b1, base + 8'(4 * i)};
	endfunction : pick
	// One cycle of stimulus at the falling edge, checked after the next rising edge
	task step(input logic [31:0] u, input logic [13:0] f, input logic [1:0] en, input logic [15:0] a);
		logic [8:0] ru, rf;
		up = u;
		fp = f;
		{ue, fe} = en;
		ca = a;
		ru = pick(u & ~USB_RSV, 32, 8'h00);
		rf = pick({18'h0, f}, 14, 8'h80);
		@(posedge clk);
		#1;
		if (ru[8]) euv = ru[7:0];
		if (rf[8]) efv = rf[7:0];
		check("usb irq", {7'h0, ui}, {7'h0, ru[8]});
		check("usb vector", uvb, euv);
		check("fifo irq", {7'h0, fi}, {7'h0, rf[8]});
		check("fifo vector", fvb, efv);
		check("fetch", cf, (a == USB_VEC_ADDR && en[1]) ? euv : (a == FIFO_VEC_ADDR && en[0]) ? efv : cr);
		@(negedge clk);
	endtask : step
	task print_verdict;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// Reset, walk every slot alone, then random mixes of sources, enables and addresses
	initial begin
		{arst_n, ue, fe, up, fp, ca} = '0;
		{euv, efv} = 16'h0080;
		n_fail = 0;
		compares = 0;
		void'($urandom(43));
		repeat (12) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		check("reset usb vector", uvb, 8'h00);
		check("reset fifo vector", fvb, 8'h80);
		for (int i = 0; i < 32; i++) step(32'h1 << i, 14'h1 << (i % 14), 2'(i), 16'h0045 + 16'((i % 2) * 16));
		$display("test walk done");
		// Reset in mid-run after the highest slots won: everything returns to reset values
		up = 32'h8000_0000;
		fp = 14'h2000;
		@(posedge clk);
		@(negedge clk);
		arst_n = 1'b0;
		#1;
		check("mid reset usb irq", {7'h0, ui}, 8'h00);
		check("mid reset fifo irq", {7'h0, fi}, 8'h00);
		check("mid reset usb vector", uvb, 8'h00);
		check("mid reset fifo vector", fvb, 8'h80);
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		{euv, efv} = 16'h0080;
		$display("test reset done");
		for (int i = 0; i < 300; i++) step((i % 5 == 0) ? 32'h0 : $urandom & $urandom & $urandom,
			14'($urandom & $urandom), 2'($urandom), 16'h0043 + 16'($urandom % 3) + 16'(($urandom % 2) * 16));
		$display("test random done");
		print_verdict;
	end
	// Watchdog well beyond the expected run time
	initial begin
		#50000;
		n_fail++;
		print_verdict;
	end
endmodule : testbench
